// File: core/snvm_port.v
/*
 * Serial slave port of a 512 x 8 nonvolatile byte memory, modes 0 and 3.
 * Assumes all pins come from the bus master, asynchronous to i_sys_clk,
 * and that the serial clock stays well below a quarter of i_sys_clk.
 */
`timescale 1ns/1ps
`include "snvm_map.vh"

module snvm_port #(
   parameter AW = `SNVM_ADDR_W,
   parameter DW = `SNVM_DATA_W,
   parameter DEPTH = `SNVM_DEPTH
) (
   // clock and reset
   input wire i_sys_clk,
   input wire i_resetn,
   // serial pins from the master
   input wire i_sel_n,
   input wire i_sck,
   input wire i_sdi,
   input wire i_pause_n,
   input wire i_wguard_n,
   // serial output pin
   output reg o_sdo,
   output reg o_sdo_oe_n
);

   localparam [6:0] ST_IDLE = 7'b0000001;
   localparam [6:0] ST_CMD = 7'b0000010;
   localparam [6:0] ST_ADDR = 7'b0000100;
   localparam [6:0] ST_WDATA = 7'b0001000;
   localparam [6:0] ST_RDATA = 7'b0010000;
   localparam [6:0] ST_SR_IN = 7'b0100000;
   localparam [6:0] ST_SR_OUT = 7'b1000000;

   // pin order: sel_n, sck, sdi, pause_n, wguard_n
   localparam [4:0] PIN_RST = 5'h1B;

   wire [4:0] pins = {i_sel_n, i_sck, i_sdi, i_pause_n, i_wguard_n};
   reg [4:0] sy1_r, sy2_r, sy3_r, flt_r;
   reg [6:0] st_r;
   reg [2:0] bit_r;
   reg [DW-2:0] in_sh_r;
   reg [DW-1:0] out_sh_r;
   reg [AW-1:0] addr_r;
   reg [1:0] bp_r;
   reg latch_r;
   reg wcmd_r;
   reg rcmd_r;
   reg drive_r;
   reg rd_en_r;
   reg load_r;
   reg wr_en_r;
   reg [DW-1:0] wr_data_r;
   reg [AW-1:0] wr_addr_r;
   wire [DW-1:0] rd_data;

   // a change counts only once the second and third stages agree
   wire [4:0] agree = ~(sy2_r ^ sy3_r);
   wire [4:0] flt_nxt = (agree & sy3_r) | (~agree & flt_r);
   wire sel_f = flt_r[4];
   wire pause_f = flt_r[1];
   wire guard_f = flt_r[0];
   // pause masks edges
   // edges seen during a pause are dropped, never replayed
   wire live = pause_f & flt_nxt[1];
   wire sck_rise = live & ~sel_f & ~flt_nxt[4] & flt_nxt[3] & ~flt_r[3];
   wire sck_fall = live & ~sel_f & ~flt_nxt[4] & ~flt_nxt[3] & flt_r[3];
   wire sel_fall = live & sel_f & ~flt_nxt[4];
   wire sel_rise = live & ~sel_f & flt_nxt[4];
   wire [DW-1:0] byte_in = {in_sh_r, sy3_r[2]};
   wire byte_done = sck_rise & (bit_r == 3'd7);
   wire [7:0] status = {4'h0, bp_r, latch_r, 1'b0};
   wire [AW-1:0] addr_inc = addr_r + {{(AW-1){1'b0}}, 1'b1};

   reg prot_hit;
   always @* begin
      case (bp_r)
         `SNVM_BP_QUARTER: prot_hit = (addr_r[AW-1:AW-2] == 2'b11);
         `SNVM_BP_HALF: prot_hit = addr_r[AW-1];
         `SNVM_BP_ALL: prot_hit = 1'b1;
         default: prot_hit = 1'b0;
      endcase
   end
   wire wr_ok = guard_f & latch_r;

   snvm_array #(
      .AW(AW),
      .DW(DW),
      .DEPTH(DEPTH)
   ) u_array (
      .i_sys_clk(i_sys_clk),
      .i_wr_en(wr_en_r),
      .i_wr_addr(wr_addr_r),
      .i_wr_data(wr_data_r),
      .i_rd_en(rd_en_r),
      .i_rd_addr(addr_r),
      .o_rd_data(rd_data)
   );

   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sy1_r <= PIN_RST;
         sy2_r <= PIN_RST;
         sy3_r <= PIN_RST;
         flt_r <= PIN_RST;
      end else begin
         sy1_r <= pins;
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         flt_r <= flt_nxt;
      end
   end

   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= ST_IDLE;
         bit_r <= 3'h0;
         in_sh_r <= 7'h00;
         out_sh_r <= 8'h00;
         addr_r <= {AW{1'b0}};
         bp_r <= `SNVM_BP_RST;
         latch_r <= `SNVM_LATCH_RST;
         wcmd_r <= 1'b0;
         rcmd_r <= 1'b0;
         drive_r <= 1'b0;
         rd_en_r <= 1'b0;
         load_r <= 1'b0;
         wr_en_r <= 1'b0;
         wr_data_r <= 8'h00;
         wr_addr_r <= {AW{1'b0}};
         o_sdo <= 1'b0;
         o_sdo_oe_n <= 1'b1;
      end else begin
         rd_en_r <= 1'b0;
         wr_en_r <= 1'b0;
         load_r <= rd_en_r;
         // read data ready before next fall
         if (load_r) begin
            out_sh_r <= rd_data;
         end
         if (sel_rise) begin
            st_r <= ST_IDLE;
            drive_r <= 1'b0;
            if (wcmd_r) begin
               latch_r <= 1'b0;
            end
            wcmd_r <= 1'b0;
         end else if (sel_fall) begin
            st_r <= ST_CMD;
            bit_r <= 3'h0;
            drive_r <= 1'b0;
            // a deselect hidden by a pause still ends a write
            if (wcmd_r) begin
               latch_r <= 1'b0;
            end
            wcmd_r <= 1'b0;
         end else if (sck_rise) begin
            bit_r <= bit_r + 3'd1;
            in_sh_r <= byte_in[DW-2:0];
            if (byte_done) begin
               case (st_r)
                  ST_CMD: begin
                     if (byte_in == `SNVM_OP_SET_LATCH) begin
                        latch_r <= 1'b1;
                        st_r <= ST_IDLE;
                     end else if (byte_in == `SNVM_OP_CLR_LATCH) begin
                        latch_r <= 1'b0;
                        st_r <= ST_IDLE;
                     end else if (byte_in == `SNVM_OP_STAT_FETCH) begin
                        out_sh_r <= status;
                        st_r <= ST_SR_OUT;
                     end else if (byte_in == `SNVM_OP_STAT_STORE) begin
                        st_r <= ST_SR_IN;
                     end else if (byte_in[7:4] == `SNVM_OP_HI_NIBBLE &&
                                  (byte_in[2:0] == `SNVM_OP_READ_LO || byte_in[2:0] == `SNVM_OP_WRITE_LO)) begin
                        addr_r[AW-1] <= byte_in[`SNVM_OP_ABIT];
                        wcmd_r <= (byte_in[2:0] == `SNVM_OP_WRITE_LO) & latch_r;
                        st_r <= ST_ADDR;
                        // kept apart: the shifter moves on with the address
                        rcmd_r <= byte_in[0];
                     end else begin
                        st_r <= ST_IDLE;
                     end
                  end
                  ST_ADDR: begin
                     addr_r[AW-2:0] <= byte_in;
                     if (rcmd_r) begin
                        st_r <= ST_RDATA;
                     end else begin
                        st_r <= ST_WDATA;
                     end
                  end
                  ST_WDATA: begin
                     wr_en_r <= wr_ok & ~prot_hit;
                     wr_addr_r <= addr_r;
                     wr_data_r <= byte_in;
                     addr_r <= addr_inc;
                  end
                  ST_SR_IN: begin
                     if (wr_ok) begin
                        bp_r <= byte_in[`SNVM_SR_BP1_BIT:`SNVM_SR_BP0_BIT];
                        wcmd_r <= 1'b1;
                     end
                     st_r <= ST_IDLE;
                  end
                  ST_RDATA: begin
                     addr_r <= addr_inc;
                  end
                  ST_SR_OUT: begin
                     // status repeats while clocked on
                     out_sh_r <= status;
                  end
                  default: begin
                     st_r <= ST_IDLE;
                  end
               endcase
            end
         end else if (sck_fall) begin
            if (st_r == ST_RDATA || st_r == ST_SR_OUT) begin
               drive_r <= 1'b1;
               o_sdo <= out_sh_r[DW-1];
               out_sh_r <= {out_sh_r[DW-2:0], 1'b0};
            end
         end
         // fetch once address known and after each outgoing byte
         if (byte_done && ((st_r == ST_ADDR && rcmd_r) || st_r == ST_RDATA)) begin
            rd_en_r <= 1'b1;
         end
         // drive only read or status data, off during pause
         o_sdo_oe_n <= ~(drive_r & pause_f & ~sel_f & ~flt_nxt[4]);
      end
   end

endmodule // snvm_port

// File: core/snvm_map.vh
/*
 * Constants for the serial nonvolatile memory port: opcodes, status
 * register layout, reset values and array geometry.
 * Included by bare name from the port core file; definitions only.
 */
`ifndef SNVM_MAP_VH
`define SNVM_MAP_VH

// array geometry
`define SNVM_ADDR_W 9
`define SNVM_DATA_W 8
`define SNVM_DEPTH 512

// opcodes
`define SNVM_OP_SET_LATCH 8'h06
`define SNVM_OP_CLR_LATCH 8'h04
`define SNVM_OP_STAT_FETCH 8'h05
`define SNVM_OP_STAT_STORE 8'h01
`define SNVM_OP_HI_NIBBLE 4'h0
`define SNVM_OP_READ_LO 3'h3
`define SNVM_OP_WRITE_LO 3'h2
`define SNVM_OP_ABIT 3

// status register fields
`define SNVM_SR_LATCH_BIT 1
`define SNVM_SR_BP0_BIT 2
`define SNVM_SR_BP1_BIT 3

// reset values
`define SNVM_BP_RST 2'h0
`define SNVM_LATCH_RST 1'h0

// block protection encodings, compared with address bits [8:7]
`define SNVM_BP_NONE 2'h0
`define SNVM_BP_QUARTER 2'h1
`define SNVM_BP_HALF 2'h2
`define SNVM_BP_ALL 2'h3

`endif

// File: core/snvm_array.v
/*
 * Byte array of the memory port: one write port, one read port, read
 * data registered.
 * Assumes the caller never asks to read and write in the same cycle.
 */
`timescale 1ns/1ps
module snvm_array #(
   parameter AW = 9,
   parameter DW = 8,
   parameter DEPTH = 512
) (
   // clock
   input wire i_sys_clk,
   // write port
   input wire i_wr_en,
   input wire [AW-1:0] i_wr_addr,
   input wire [DW-1:0] i_wr_data,
   // read port
   input wire i_rd_en,
   input wire [AW-1:0] i_rd_addr,
   output reg [DW-1:0] o_rd_data
);

   reg [DW-1:0] mem [0:DEPTH-1];

   // contents are not reset: they model nonvolatile storage
   always @(posedge i_sys_clk) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
      if (i_rd_en) begin
         o_rd_data <= mem[i_rd_addr];
      end
   end

endmodule // snvm_array

// File: bench/snvm_host_model.sv
/* bus master model for the serial memory port
   assumes its tasks are called at falling edges of i_sys_clk */
`timescale 1ns/1ps
module snvm_host_model (
   // clock and device output
   input wire i_sys_clk,
   input wire i_sdo,
   input wire i_sdo_oe_n,
   // pins to the device
   output reg o_sel_n = 1'b1,
   output reg o_sck = 1'b0,
   output reg o_sdi = 1'b0,
   output reg o_pause_n = 1'b1
);
   // released line reads inverted, never a stale bit
   wire miso = i_sdo_oe_n ? ~i_sdo : i_sdo;
   task automatic w(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask
   task automatic start(input bit m3);
      o_sck = m3;
      w(8);
      o_sel_n = 1'b0;
      w(6);
   endtask
   task automatic stop(input bit m3);
      o_sck = m3;
      w(6);
      o_sel_n = 1'b1;
      w(8);
   endtask
   task automatic xfer(input [7:0] tx, input int hold_at, output [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_sck = 1'b0;
         o_sdi = tx[i];
         w(4);
         if (i == hold_at) begin
            o_pause_n = 1'b0;
            w(6);
            {o_sck, o_sel_n} = 2'b11;
            w(6);
            {o_sck, o_sel_n} = 2'b00;
            w(6);
            o_pause_n = 1'b1;
            w(6);
         end
         o_sck = 1'b1;
         w(4);
         rx[i] = miso;
      end
   endtask
endmodule // snvm_host_model

// File: bench/snvm_port_assertions.sv
/* pin assertions for snvm_port, bound below
   assumes serial clock phases of at least 4 i_sys_clk cycles */
`timescale 1ns/1ps
module snvm_port_assertions (
   // clock and reset
   input wire i_sys_clk,
   input wire i_resetn,
   // master pins
   input wire i_sel_n,
   input wire i_sck,
   input wire i_pause_n,
   // device output
   input wire o_sdo,
   input wire o_sdo_oe_n
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_resetn);
   sequence s_idle;
      i_sel_n [*8];
   endsequence
   sequence s_held;
      !i_pause_n [*8];
   endsequence
   a_idle_tristate: assert property (s_idle |-> o_sdo_oe_n)
      else $error("sdo driven while idle");
   a_held_tristate: assert property (s_held |-> o_sdo_oe_n)
      else $error("sdo driven while held");
   a_reset_quiet: assert property ($rose(i_resetn) |-> o_sdo_oe_n && !o_sdo)
      else $error("sdo active after reset");
   a_sdo_on_fall: assert property (!o_sdo_oe_n && !$past(o_sdo_oe_n) && $changed(o_sdo) |-> !$past(i_sck, 4))
      else $error("sdo moved off a fall");
   a_oe_on_fall: assert property ($fell(o_sdo_oe_n) |-> !$past(i_sck, 5))
      else $error("sdo enabled off a fall");
   a_oe_needs_sel: assert property ($fell(o_sdo_oe_n) |-> !$past(i_sel_n, 3) && $past(i_pause_n, 3))
      else $error("sdo enabled while idle");
   a_sel_release: assert property ($rose(i_sel_n) |-> ##[1:8] o_sdo_oe_n)
      else $error("sdo kept after select");
   a_hold_release: assert property ($fell(i_pause_n) |-> ##[1:8] o_sdo_oe_n)
      else $error("sdo kept after pause");
endmodule // snvm_port_assertions

bind snvm_port snvm_port_assertions i_snvm_port_assertions (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
   .i_sel_n(i_sel_n), .i_sck(i_sck), .i_pause_n(i_pause_n), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n));

// File: bench/snvm_port_tb.sv
/* self-checking bench: snvm_port against snvm_host_model
   assumes the checker binds itself to snvm_port */
`timescale 1ns/1ps
module snvm_port_tb;
   typedef struct packed {logic [3:0] f; logic [8:0] a; logic [7:0] d, exp;} snvm_row_t;
   // f: mode 3, latch set, latch cleared, guard; then address, data, read back
   snvm_row_t rows [7] = '{'{4'h5, 9'h1A5, 8'h3C, 8'h3C}, '{4'h9, 9'h1A5, 8'h77, 8'h3C},
      '{4'h4, 9'h1A5, 8'h55, 8'h3C}, '{4'hF, 9'h1A5, 8'h66, 8'h3C}, '{4'h5, 9'h0A5, 8'hC3, 8'hC3},
      '{4'hD, 9'h1FF, 8'h81, 8'h81}, '{4'h9, 9'h1A5, 8'h00, 8'h3C}};
   snvm_row_t r;
   logic i_sys_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_wguard_n = 1'b1;
   wire sel_n, sck, sdi, pause_n, sdo, sdo_oe_n;
   logic [7:0] rx, rx_first;
   int error_cnt = 0;
   int checks = 0;
   snvm_port i_snvm_port (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_sel_n(sel_n), .i_sck(sck),
      .i_sdi(sdi), .i_pause_n(pause_n), .i_wguard_n(i_wguard_n), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n));
   snvm_host_model i_snvm_host_model (.i_sys_clk(i_sys_clk), .i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n),
      .o_sel_n(sel_n), .o_sck(sck), .o_sdi(sdi), .o_pause_n(pause_n));
   initial begin
      forever #10 i_sys_clk = ~i_sys_clk;
   end
   task automatic test_done;
      if (error_cnt == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input [7:0] got, input [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmd(input bit m3, input [7:0] op, input bit more, input [7:0] b);
      i_snvm_host_model.start(m3);
      i_snvm_host_model.xfer(op, -1, rx);
      if (more)
         i_snvm_host_model.xfer(b, -1, rx);
      i_snvm_host_model.stop(m3);
   endtask
   task automatic mem(input bit m3, wr, input [8:0] a, input [7:0] d, d2, input bit two, input int hold);
      i_snvm_host_model.start(m3);
      i_snvm_host_model.xfer({4'h0, a[8], 2'b01, ~wr}, -1, rx);
      i_snvm_host_model.xfer(a[7:0], -1, rx);
      i_snvm_host_model.xfer(d, hold, rx);
      rx_first = rx;
      if (two)
         i_snvm_host_model.xfer(d2, -1, rx);
      i_snvm_host_model.stop(m3);
   endtask
   task automatic pulse_reset;
      i_resetn = 1'b0;
      repeat (10) @(negedge i_sys_clk);
      i_resetn = 1'b1;
      repeat (4) @(negedge i_sys_clk);
   endtask
   initial begin
      pulse_reset;
      foreach (rows[k]) begin
         r = rows[k];
         i_wguard_n = r.f[0];
         if (r.f[2])
            cmd(r.f[3], 8'h06, 1'b0, 8'h00);
         if (r.f[1])
            cmd(r.f[3], 8'h04, 1'b0, 8'h00);
         mem(r.f[3], 1'b1, r.a, r.d, 8'h00, 1'b0, -1);
         i_wguard_n = 1'b1;
         mem(r.f[3], 1'b0, r.a, 8'h00, 8'h00, 1'b0, -1);
         check(rx, r.exp);
      end
      cmd(1'b0, 8'h06, 1'b1, 8'h04);
      cmd(1'b1, 8'h05, 1'b1, 8'h00);
      check(rx, 8'h02);
      cmd(1'b0, 8'h01, 1'b1, 8'h04);
      cmd(1'b0, 8'h05, 1'b1, 8'h00);
      check(rx, 8'h04);
      cmd(1'b0, 8'h06, 1'b0, 8'h00);
      mem(1'b0, 1'b1, 9'h1FF, 8'h5A, 8'h00, 1'b0, -1);
      mem(1'b1, 1'b0, 9'h1FF, 8'h00, 8'h00, 1'b0, -1);
      check(rx, 8'h81);
      pulse_reset;
      cmd(1'b1, 8'h05, 1'b1, 8'h00);
      check(rx, 8'h00);
      cmd(1'b1, 8'h06, 1'b0, 8'h00);
      mem(1'b1, 1'b1, 9'h1FF, 8'h11, 8'h22, 1'b1, -1);
      mem(1'b0, 1'b0, 9'h1FF, 8'h00, 8'h00, 1'b1, 3);
      check(rx_first, 8'h11);
      check(rx, 8'h22);
      mem(1'b0, 1'b0, 9'h000, 8'h00, 8'h00, 1'b0, -1);
      check(rx, 8'h22);
      test_done;
   end
   // normal run is near 118 us
   initial begin
      #1_000_000;
      error_cnt++;
      test_done;
   end
endmodule // snvm_port_tb
